/* File: rtl/ssr_regs.sv */
`timescale 1ns/1ps
`include "ssr_map.svh"
module ssr_regs #(
	parameter logic [3:0] FAM_CODE = 4'h5, // Arbitrary value
	parameter logic [3:0] PROD_CODE = 4'h3, // Arbitrary value
	parameter int SOFT_RST_CYC = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire ssr_pkg::ssr_spi_s spi_in,
	output logic miso,
	output logic miso_oe_n,
	input wire logic soft_reset_output_config,
	input wire logic restart_enter,
	input wire logic overtemp_event,
	input wire logic main_ov_event,
	input wire logic [9:0][7:0] rc_event,
	input wire logic [4:0][7:0] ro_level,
	output ssr_pkg::ssr_msc_s ctrl,
	output logic soft_reset_pulse,
	output logic reset_out_n,
	output logic ov_reaction_req
);

	// Counter below is eight bits wide
	generate
		if (SOFT_RST_CYC < 1 || SOFT_RST_CYC > 255) begin : g_chk
			$error("SOFT_RST_CYC out of range");
		end
	endgenerate

	localparam logic [7:0] RST_CYC = 8'(SOFT_RST_CYC);

	// Address to latched-status index, shared by read and clear
	function automatic logic [3:0] rc_idx(input logic [6:0] a);
		case (a)
			`SSR_ADR_SUP2: rc_idx = 4'h0;
			`SSR_ADR_SUP1: rc_idx = 4'h1;
			`SSR_ADR_THERM: rc_idx = 4'h2;
			`SSR_ADR_DEV: rc_idx = 4'h3;
			`SSR_ADR_BUS1: rc_idx = 4'h4;
			`SSR_ADR_BUS2: rc_idx = 4'h5;
			`SSR_ADR_WK1: rc_idx = 4'h6;
			`SSR_ADR_WK2: rc_idx = 4'h7;
			`SSR_ADR_HSOC: rc_idx = 4'h8;
			`SSR_ADR_HSOL: rc_idx = 4'h9;
			default: rc_idx = `SSR_RC_NONE;
		endcase
	endfunction : rc_idx

	// Implemented bits of each latched register
	function automatic logic [7:0] rc_mask(input logic [3:0] i);
		case (i)
			4'h0: rc_mask = `SSR_MSK_SUP2;
			4'h1: rc_mask = `SSR_MSK_SUP1;
			4'h2: rc_mask = `SSR_MSK_THERM;
			4'h3: rc_mask = `SSR_MSK_DEV;
			4'h4: rc_mask = `SSR_MSK_BUS1;
			4'h5: rc_mask = `SSR_MSK_BUS2;
			4'h6: rc_mask = `SSR_MSK_WK1;
			4'h7: rc_mask = `SSR_MSK_WK2;
			4'h8: rc_mask = `SSR_MSK_HSOC;
			4'h9: rc_mask = `SSR_MSK_HSOL;
			default: rc_mask = 8'h00;
		endcase
	endfunction : rc_mask

	// Address to live-status index
	function automatic logic [2:0] ro_idx(input logic [6:0] a);
		case (a)
			`SSR_ADR_WKLVL: ro_idx = 3'h0;
			`SSR_ADR_SWK: ro_idx = 3'h1;
			`SSR_ADR_ECNT: ro_idx = 3'h2;
			`SSR_ADR_CDR1: ro_idx = 3'h3;
			`SSR_ADR_CDR2: ro_idx = 3'h4;
			default: ro_idx = `SSR_RO_NONE;
		endcase
	endfunction : ro_idx

	function automatic logic [7:0] ro_mask(input logic [2:0] i);
		case (i)
			3'h0: ro_mask = `SSR_MSK_WKLVL;
			3'h1: ro_mask = `SSR_MSK_SWK;
			3'h2: ro_mask = `SSR_MSK_ECNT;
			3'h3: ro_mask = `SSR_MSK_CDR1;
			3'h4: ro_mask = `SSR_MSK_CDR2;
			default: ro_mask = 8'h00;
		endcase
	endfunction : ro_mask

	logic [2:0] pin_in;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] flt_r;
	logic [2:0] flt_d_r;
	logic sck_rise;
	logic cs_fall;
	logic cs_rise;
	logic cs_act;
	logic [15:0] in_sr_r;
	logic [7:0] out_sr_r;
	logic [4:0] cnt_r;
	logic rw_r;
	logic [6:0] addr_r;
	ssr_pkg::ssr_phase_e ph_r;
	logic [6:0] rd_addr;
	logic [7:0] rd_val;
	logic frame_ok;
	logic wr_cmd;
	logic [7:0] wdata;
	logic wr_msc;
	logic soft_trig;
	ssr_pkg::ssr_msc_s msc_r;
	ssr_pkg::ssr_msc_s msc_nxt;
	logic [9:0][7:0] rc_r;
	logic [7:0] rst_cnt_r;
	logic miso_r;
	logic miso_oe_n_r;
	logic soft_pulse_r;
	logic rst_n_r;
	logic ov_req_r;

	assign pin_in = {spi_in.sck, spi_in.cs_n, spi_in.mosi};

	// Idle levels of the link pins, so no false edge follows reset
	localparam logic [2:0] PIN_IDLE = `SSR_PIN_IDLE;

	// Three-stage pin capture; a level is taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					s1_r[gi] <= PIN_IDLE[gi];
					s2_r[gi] <= PIN_IDLE[gi];
					s3_r[gi] <= PIN_IDLE[gi];
					flt_r[gi] <= PIN_IDLE[gi];
					flt_d_r[gi] <= PIN_IDLE[gi];
				end else if (clk_en) begin
					s1_r[gi] <= pin_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						flt_r[gi] <= s3_r[gi];
					end
					flt_d_r[gi] <= flt_r[gi];
				end
			end
		end
	endgenerate

	// Edges of the filtered link signals
	assign cs_act = ~flt_r[1];
	assign sck_rise = flt_r[2] & ~flt_d_r[2] & cs_act;
	assign cs_fall = ~flt_r[1] & flt_d_r[1];
	assign cs_rise = flt_r[1] & ~flt_d_r[1];

	// Address of the frame as it completes its first byte
	assign rd_addr = in_sr_r[15:9];

	// Read mux; unmapped addresses answer zero
	always_comb begin
		rd_val = 8'h00;
		if (rd_addr == `SSR_ADR_MSC) begin
			rd_val = msc_r;
		end else if (rd_addr == `SSR_ADR_ID) begin
			rd_val = {FAM_CODE, PROD_CODE};
		end else if (rc_idx(rd_addr) != `SSR_RC_NONE) begin
			rd_val = rc_r[rc_idx(rd_addr)];
		end else if (ro_idx(rd_addr) != `SSR_RO_NONE) begin
			rd_val = ro_level[ro_idx(rd_addr)] & ro_mask(ro_idx(rd_addr));
		end
	end

	// Input shifting and bit count; LSB of the frame first
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			in_sr_r <= 16'h0000;
			cnt_r <= 5'h00;
			rw_r <= 1'b0;
			addr_r <= 7'h00;
		end else if (clk_en) begin
			if (cs_fall) begin
				cnt_r <= 5'h00;
			end else if (sck_rise) begin
				in_sr_r <= {flt_r[0], in_sr_r[15:1]};
				if (cnt_r != `SSR_CNT_MAX) begin
					cnt_r <= cnt_r + 5'h01;
				end
				if (cnt_r == `SSR_ADDR_DONE) begin
					rw_r <= flt_r[0];
					addr_r <= rd_addr;
				end
			end
		end
	end

	// Frame phase; a select edge always restarts or ends the frame
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ph_r <= ssr_pkg::ph_idle;
		end else if (clk_en) begin
			if (cs_fall) begin
				ph_r <= ssr_pkg::ph_addr;
			end else if (cs_rise) begin
				ph_r <= ssr_pkg::ph_idle;
			end else if (sck_rise) begin
				case (ph_r)
					ssr_pkg::ph_addr: begin
						if (cnt_r == `SSR_ADDR_DONE) begin
							ph_r <= ssr_pkg::ph_data;
						end
					end
					ssr_pkg::ph_data: begin
						if (cnt_r == `SSR_FRAME_BITS - 5'h01) begin
							ph_r <= ssr_pkg::ph_over;
						end
					end
					ssr_pkg::ph_over: begin
						ph_r <= ssr_pkg::ph_over; // Extra bits push the count past 16
					end
					default: begin
						ph_r <= ssr_pkg::ph_idle;
					end
				endcase
			end
		end
	end

	// Output shifting; old content loaded before any write lands
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			out_sr_r <= 8'h00;
			miso_r <= 1'b0;
			miso_oe_n_r <= 1'b1;
		end else if (clk_en) begin
			miso_oe_n_r <= ~cs_act;
			if (cs_fall) begin
				out_sr_r <= rc_r[3];
				miso_r <= rc_r[3][0];
			end else if (sck_rise) begin
				if (cnt_r == `SSR_ADDR_DONE) begin
					out_sr_r <= rd_val;
					miso_r <= rd_val[0];
				end else begin
					out_sr_r <= {1'b0, out_sr_r[7:1]};
					miso_r <= out_sr_r[1];
				end
			end else if (cs_rise) begin
				out_sr_r <= 8'h00; // Idle line reads low, whatever a cut frame left
				miso_r <= 1'b0;
			end
		end
	end

	// Only a complete 16-bit frame acts; short or long ones are dropped
	assign frame_ok = cs_rise && (cnt_r == `SSR_FRAME_BITS) && (ph_r == ssr_pkg::ph_over);
	assign wr_cmd = frame_ok && rw_r;
	assign wdata = in_sr_r[15:8];
	assign wr_msc = wr_cmd && (addr_r == `SSR_ADR_MSC);
	assign soft_trig = wr_msc && (wdata[7:6] == 2'b11) && !restart_enter;

	// Next control value; restart outranks soft reset, soft reset outranks write
	always_comb begin
		msc_nxt = msc_r;
		if (wr_msc) begin
			msc_nxt = wdata;
			if (msc_r.mode == ssr_pkg::mode_stop && wdata[7:6] == 2'b01) begin
				msc_nxt.mode = msc_r.mode;
			end
		end
		if (overtemp_event) begin
			msc_nxt.secondary_regulator_select = 2'b00;
		end
		if (soft_trig) begin
			msc_nxt = `SSR_MSC_POR;
		end
		if (restart_enter) begin
			msc_nxt = msc_r & `SSR_MSC_KEEP;
		end
	end

	// Control register; changes only by write, restart or overtemperature
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			msc_r <= `SSR_MSC_POR;
		end else if (clk_en) begin
			msc_r <= msc_nxt;
		end
	end

	// Latched flags; a new event beats a clear in the same cycle
	generate
		for (gi = 0; gi < 10; gi++) begin : g_rc
			logic clr;
			logic [7:0] ev;
			assign clr = wr_cmd && (rc_idx(addr_r) == 4'(gi));
			assign ev = (gi == 0 && main_ov_event) ? (rc_event[gi] | `SSR_OV_FLAG)
				: rc_event[gi];
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					rc_r[gi] <= 8'h00;
				end else if (clk_en) begin
					rc_r[gi] <= ((clr ? 8'h00 : rc_r[gi]) | ev) & rc_mask(4'(gi));
				end
			end
		end
	endgenerate

	// Reset output pulse on soft reset, width set by parameter
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_cnt_r <= 8'h00;
			rst_n_r <= 1'b1;
			soft_pulse_r <= 1'b0;
		end else if (clk_en) begin
			soft_pulse_r <= soft_trig;
			if (soft_trig && !soft_reset_output_config) begin
				rst_cnt_r <= RST_CYC;
				rst_n_r <= 1'b0;
			end else if (rst_cnt_r > 8'h01) begin
				rst_cnt_r <= rst_cnt_r - 8'h01;
			end else if (rst_cnt_r == 8'h01) begin
				rst_cnt_r <= 8'h00;
				rst_n_r <= 1'b1;
			end
		end
	end

	// Overvoltage reaction only when enabled
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ov_req_r <= 1'b0;
		end else if (clk_en) begin
			ov_req_r <= main_ov_event && msc_r.main_overvoltage_reaction_enable;
		end
	end

	// All outputs straight from flops
	assign ctrl = msc_r;
	assign miso = miso_r;
	assign miso_oe_n = miso_oe_n_r;
	assign soft_reset_pulse = soft_pulse_r;
	assign reset_out_n = rst_n_r;
	assign ov_reaction_req = ov_req_r;

endmodule : ssr_regs

/* File: inc/ssr_map.svh */
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
// Register addresses, 7-bit
`define SSR_ADR_MSC 7'h01
`define SSR_ADR_SUP2 7'h40
`define SSR_ADR_SUP1 7'h41
`define SSR_ADR_THERM 7'h42
`define SSR_ADR_DEV 7'h43
`define SSR_ADR_BUS1 7'h44
`define SSR_ADR_BUS2 7'h45
`define SSR_ADR_WK1 7'h46
`define SSR_ADR_WK2 7'h47
`define SSR_ADR_WKLVL 7'h48
`define SSR_ADR_HSOC 7'h54
`define SSR_ADR_HSOL 7'h55
`define SSR_ADR_SWK 7'h70
`define SSR_ADR_ECNT 7'h71
`define SSR_ADR_CDR1 7'h72
`define SSR_ADR_CDR2 7'h73
`define SSR_ADR_ID 7'h7e
// Implemented-bit masks, reserved bits read zero
`define SSR_MSK_SUP2 8'h5f
`define SSR_MSK_SUP1 8'hff
`define SSR_MSK_THERM 8'h07
`define SSR_MSK_DEV 8'hcf
`define SSR_MSK_BUS1 8'h7f
`define SSR_MSK_BUS2 8'h06
`define SSR_MSK_WK1 8'hf7
`define SSR_MSK_WK2 8'h30
`define SSR_MSK_HSOC 8'h0f
`define SSR_MSK_HSOL 8'h0f
`define SSR_MSK_WKLVL 8'hf7
`define SSR_MSK_SWK 8'h4f
`define SSR_MSK_ECNT 8'h3f
`define SSR_MSK_CDR1 8'hff
`define SSR_MSK_CDR2 8'hf0
// Mode and supply control values
`define SSR_MSC_POR 8'h00
`define SSR_MSC_KEEP 8'h23
`define SSR_OV_FLAG 8'h02
// Frame layout and timing
`define SSR_FRAME_BITS 5'h10
`define SSR_ADDR_DONE 5'h07
`define SSR_CNT_MAX 5'h1f
`define SSR_PIN_IDLE 3'h2
`define SSR_RC_NONE 4'hf
`define SSR_RO_NONE 3'h7
`endif

/* File: inc/ssr_pkg.sv */
package ssr_pkg;
	// Chip mode field encodings
	typedef enum logic [1:0] {
		mode_normal = 2'b00,
		mode_sleep = 2'b01,
		mode_stop = 2'b10,
		mode_soft_reset = 2'b11
	} ssr_mode_e;
	// Mode and supply control, bit 7 first
	typedef struct packed {
		ssr_mode_e mode;
		logic aux_regulator_enable;
		logic [1:0] secondary_regulator_select;
		logic main_overvoltage_reaction_enable;
		logic [1:0] reset_threshold_select;
	} ssr_msc_s;
	// Serial pins as seen at the device
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} ssr_spi_s;
	// Frame phase
	typedef enum logic [1:0] {
		ph_idle = 2'b00,
		ph_addr = 2'b01,
		ph_data = 2'b10,
		ph_over = 2'b11
	} ssr_phase_e;
endpackage : ssr_pkg

/* File: bench/ssr_regs_assertions.sv */
`timescale 1ns/1ps
// Port-level checks on the mode and status register bank
module ssr_regs_assertions #(
	parameter int SOFT_RST_CYC = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire ssr_pkg::ssr_spi_s spi_in,
	input wire logic miso,
	input wire logic miso_oe_n,
	input wire logic soft_reset_output_config,
	input wire logic restart_enter,
	input wire logic overtemp_event,
	input wire logic main_ov_event,
	input wire ssr_pkg::ssr_msc_s ctrl,
	input wire logic soft_reset_pulse,
	input wire logic reset_out_n,
	input wire logic ov_reaction_req
);
	logic [7:0] c;
	logic [7:0] low_r;
	// Flat view of the control register
	assign c = ctrl;
	// Length of the last low stretch of the reset output
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			low_r <= 8'h00;
		end else if (clk_en) begin
			low_r <= reset_out_n ? 8'h00 : low_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	ov_react_a: assert property ($past(arst_n) && $past(clk_en) |->
		ov_reaction_req == $past(main_ov_event && c[2])) else $error("overvoltage reaction wrong");
	restart_keep_a: assert property (restart_enter && clk_en |=>
		c == ($past(c) & 8'h23)) else $error("restart value wrong");
	ot_clear_a: assert property (overtemp_event && clk_en |=>
		c[4:3] == 2'b00) else $error("secondary field not cleared");
	pulse_one_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse too long");
	soft_out_a: assert property (soft_reset_pulse |->
		reset_out_n == soft_reset_output_config) else $error("reset output wrong");
	low_span_a: assert property (clk_en && $rose(reset_out_n) |->
		low_r == SOFT_RST_CYC) else $error("reset output low span wrong");
	oe_idle_a: assert property (spi_in.cs_n [*7] |-> miso_oe_n)
		else $error("output enabled while deselected");
	miso_idle_a: assert property (miso_oe_n |-> !miso)
		else $error("serial output not low when idle");
	ctrl_quiet_a: assert property ($changed(c) && !$past(restart_enter) &&
		!$past(overtemp_event) |-> $past(spi_in.cs_n)) else $error("control changed alone");
endmodule : ssr_regs_assertions

bind ssr_regs ssr_regs_assertions #(.SOFT_RST_CYC(SOFT_RST_CYC)) chk_i (
	.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .spi_in(spi_in), .miso(miso),
	.miso_oe_n(miso_oe_n), .soft_reset_output_config(soft_reset_output_config),
	.restart_enter(restart_enter), .overtemp_event(overtemp_event),
	.main_ov_event(main_ov_event), .ctrl(ctrl), .soft_reset_pulse(soft_reset_pulse),
	.reset_out_n(reset_out_n), .ov_reaction_req(ov_reaction_req));

/* File: bench/ssr_spi_host.sv */
`timescale 1ns/1ps
// Host side of the serial link: mode 0, LSB first, 800 ns bit period
module ssr_spi_host (
	input wire logic clk_sys,
	output ssr_pkg::ssr_spi_s spi_in,
	input wire logic miso
);
	// Clock stands low and select high between frames
	initial spi_in = 3'h2;
	task automatic gap(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : gap
	// Frames of other than 16 bits serve the refusal case
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		spi_in.cs_n = 1'b0;
		spi_in.mosi = tx[0];
		gap(8);
		for (int i = 0; i < n; i++) begin
			rx[i] = miso;
			spi_in.sck = 1'b1;
			gap(4);
			spi_in.sck = 1'b0;
			spi_in.mosi = (i < n - 1) ? tx[i + 1] : tx[i];
			gap(4);
		end
		gap(4);
		spi_in.cs_n = 1'b1;
		spi_in.mosi = ~spi_in.mosi; // Released line must not look driven
		gap(8);
	endtask : frame
endmodule : ssr_spi_host

/* File: bench/ssr_regs_tb.sv */
`timescale 1ns/1ps
module ssr_regs_tb;
	localparam logic [3:0] FAM = 4'h9; // Arbitrary code
	localparam logic [3:0] PROD = 4'h6; // Arbitrary code
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic ro_cfg = 1'b0;
	logic restart_enter = 1'b0;
	logic overtemp_event = 1'b0;
	logic main_ov_event = 1'b0;
	logic [9:0][7:0] rc_event = '0;
	logic [4:0][7:0] ro_level = '0;
	ssr_pkg::ssr_spi_s spi_in;
	ssr_pkg::ssr_msc_s ctrl;
	logic miso;
	logic reset_out_n;
	logic miso_oe_n;
	logic soft_reset_pulse;
	logic ov_reaction_req;
	logic oe_low = 1'b0;
	int rst_low_cnt = 0;
	int soft_cnt = 0;
	localparam int RST_CYC = 2;
	int errors = 0;
	int samples_checked = 0;
	// Clock 10 MHz
	always #50 clk_sys = ~clk_sys;
	ssr_spi_host host (.clk_sys(clk_sys), .spi_in(spi_in), .miso(miso));
	ssr_regs #(.FAM_CODE(FAM), .PROD_CODE(PROD), .SOFT_RST_CYC(RST_CYC)) dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .spi_in(spi_in), .miso(miso),
		.miso_oe_n(miso_oe_n), .soft_reset_output_config(ro_cfg), .restart_enter(restart_enter),
		.overtemp_event(overtemp_event), .main_ov_event(main_ov_event), .rc_event(rc_event),
		.ro_level(ro_level), .ctrl(ctrl), .soft_reset_pulse(soft_reset_pulse),
		.reset_out_n(reset_out_n), .ov_reaction_req(ov_reaction_req));
	// Short outputs are caught here, they are gone once a frame task returns
	always @(posedge clk_sys) begin
		if (!miso_oe_n) begin
			oe_low <= 1'b1;
		end
		if (!reset_out_n) begin
			rst_low_cnt <= rst_low_cnt + 1;
		end
		if (soft_reset_pulse) begin
			soft_cnt <= soft_cnt + 1;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk
	// Full frame, data byte returned is compared
	task automatic xc(input logic [6:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
		logic [15:0] rx;
		oe_low = 1'b0;
		host.frame({d, w, a}, 16, rx);
		chk(rx[15:8], e);
		chk({6'h00, oe_low, miso_oe_n}, 8'h03);
	endtask : xc
	task automatic t_por();
		xc(7'h01, 1'b0, 8'h00, 8'h00);
		xc(7'h7e, 1'b1, 8'h00, {FAM, PROD});
		xc(7'h7e, 1'b0, 8'h00, {FAM, PROD});
		xc(7'h10, 1'b0, 8'h00, 8'h00);
		$display("test por done");
	endtask : t_por
	task automatic t_mode();
		xc(7'h01, 1'b1, 8'h1a, 8'h00);
		xc(7'h01, 1'b0, 8'hff, 8'h1a);
		xc(7'h01, 1'b1, 8'hbe, 8'h1a);
		xc(7'h01, 1'b1, 8'h66, 8'hbe);
		chk(ctrl, 8'ha6);
		xc(7'h01, 1'b1, 8'hbe, 8'ha6);
		main_ov_event = 1'b1;
		host.gap(1);
		main_ov_event = 1'b0;
		chk({7'h00, ov_reaction_req}, 8'h01);
		xc(7'h40, 1'b0, 8'h00, 8'h02);
		restart_enter = 1'b1;
		host.gap(1);
		restart_enter = 1'b0;
		host.gap(1);
		chk(ctrl, 8'h22);
		xc(7'h01, 1'b1, 8'h3a, 8'h22);
		overtemp_event = 1'b1;
		host.gap(1);
		overtemp_event = 1'b0;
		host.gap(1);
		chk(ctrl, 8'h22);
		$display("test mode done");
	endtask : t_mode
	task automatic t_flags();
		logic [15:0] rx;
		rc_event[0] = 8'hff;
		ro_level[0] = 8'hff;
		host.gap(1);
		rc_event[0] = 8'h00;
		xc(7'h40, 1'b0, 8'h00, 8'h5f);
		xc(7'h40, 1'b1, 8'h00, 8'h5f);
		xc(7'h40, 1'b0, 8'h00, 8'h00);
		xc(7'h48, 1'b1, 8'h00, 8'hf7);
		xc(7'h48, 1'b0, 8'h00, 8'hf7);
		host.frame({8'h25, 1'b1, 7'h01}, 15, rx);
		chk(ctrl, 8'h22);
		$display("test flags done");
	endtask : t_flags
	// Clock enable low: restart and events are ignored, nothing moves
	task automatic t_hold();
		xc(7'h01, 1'b1, 8'h3e, 8'h22);
		clk_en = 1'b0;
		restart_enter = 1'b1;
		main_ov_event = 1'b1;
		overtemp_event = 1'b1;
		host.gap(2);
		restart_enter = 1'b0;
		main_ov_event = 1'b0;
		overtemp_event = 1'b0;
		chk(ctrl, 8'h3e);
		chk({7'h00, ov_reaction_req}, 8'h00);
		clk_en = 1'b1;
		xc(7'h40, 1'b0, 8'h00, 8'h00);
		$display("test hold done");
	endtask : t_hold
	task automatic t_soft();
		rst_low_cnt = 0;
		soft_cnt = 0;
		xc(7'h01, 1'b1, 8'he3, 8'h3e);
		chk(ctrl, 8'h00);
		chk(8'(rst_low_cnt), 8'(RST_CYC));
		chk(8'(soft_cnt), 8'h01);
		ro_cfg = 1'b1;
		rst_low_cnt = 0;
		xc(7'h01, 1'b1, 8'hc3, 8'h00);
		chk(8'(rst_low_cnt), 8'h00);
		chk(8'(soft_cnt), 8'h02);
		chk({7'h00, reset_out_n}, 8'h01);
		$display("test soft done");
	endtask : t_soft
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	// Main sequence after 3 cycles of reset
	initial begin
		host.gap(3);
		arst_n = 1'b1;
		host.gap(2);
		t_por();
		t_mode();
		t_flags();
		t_hold();
		t_soft();
		wrap_up();
	end
	// Watchdog, about six times the expected run
	initial begin
		#2000000;
		errors++;
		wrap_up();
	end
endmodule : ssr_regs_tb
